// file: design/pfc_params.svh
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PFC_REG_CTRL        8'h00
`define PFC_REG_STATUS      8'h04
`define PFC_REG_CAP         8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFC_CTRL_DEPTH_LSB  0
`define PFC_CTRL_DEPTH_MSB  7
`define PFC_CTRL_FRBF_BIT   8
`define PFC_STAT_CNT_LSB    0
`define PFC_STAT_CNT_MSB    7
`define PFC_STAT_AVAIL_BIT  8
`define PFC_STAT_BUSY_BIT   9
`define PFC_STAT_THR_BIT    10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PFC_DEPTH_RST       8'h00
`define PFC_FRBF_RST        1'b0
`define PFC_PINS_RST        5'h1F

// ----------------------------------------------------------------
// grant status codes and timing
// ----------------------------------------------------------------
`define PFC_ST_LP_READ      3'h0
`define PFC_ST_HP_READ      3'h1
`define PFC_ST_LP_WRITE     3'h2
`define PFC_ST_HP_WRITE     3'h3
`define PFC_BLOCK_CLKS      4
`define PFC_WR_LEAD_MAX     1

`endif

// file: design/pfc_pkg.sv
`default_nettype none
package pfc_pkg;

	typedef enum logic [1:0] {
		S_IDLE,
		S_WR_LEAD,
		S_XFER,
		S_THROTTLE
	} pfc_state_t;

	typedef logic [7:0] pfc_count_t;

endpackage
`default_nettype wire

// file: design/pfc_blk_cnt.sv
`include "pfc_params.svh"
`default_nettype none
module pfc_blk_cnt
	import pfc_pkg::*;
#(
	parameter int unsigned BLK_CLKS = `PFC_BLOCK_CLKS,
	parameter int unsigned LW       = 8
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	input  wire logic          load,
	input  wire logic [LW-1:0] len,
	input  wire logic          move,
	output logic               blk_end,
	output logic               last,
	output logic               initial_blk
);

	localparam int unsigned PW = (BLK_CLKS > 1) ? $clog2(BLK_CLKS) : 1;
	localparam logic [PW-1:0] POS_LAST = PW'(BLK_CLKS - 1);

	logic [LW-1:0] rem_q;
	logic [PW-1:0] pos_q;
	logic          init_q;

	assign blk_end     = move && (pos_q == POS_LAST);
	assign last        = move && (rem_q <= LW'(1));
	assign initial_blk = init_q;

	// ----------------------------------------------------------------
	// clocks left in the transaction
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rem_q <= '0;
		end else if (load) begin
			rem_q <= len;
		end else if (move && rem_q != '0) begin
			rem_q <= rem_q - LW'(1);
		end
	end

	// ----------------------------------------------------------------
	// position inside the four-clock block
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_q <= '0;
		end else if (load) begin
			pos_q <= '0;
		end else if (move) begin
			pos_q <= (pos_q == POS_LAST) ? '0 : pos_q + PW'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			init_q <= 1'b1;
		end else if (load) begin
			init_q <= 1'b1;
		end else if (move && pos_q == POS_LAST) begin
			init_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: design/pfc_master.sv
// Functional notes
// - never exceed programmed request depth
// - cap outstanding at built-in queue capacity
// - issuing read, write or flush takes slot
// - slot freed when its data starts moving
// - flush holds slot until dummy data
// - no new request while count at limit
// - throttle only at four-clock block boundaries
// - short transfer is one initial block
// - read-buffer-full holds off next low-priority return
// - read-buffer-full ignored once return granted
// - initial read block accepted without stall
// - high-priority read return never held off
// - any wait states between read blocks
// - 1x initial block carries sixteen bytes
// - high-priority subsequent blocks throttle like low
// - write grant taken at once, bus driven next clock
// - initial write block delayed one clock max
// - write data within two clocks of bus
// - subsequent write blocks never stalled
// - one slot per request, single or dual
// - short transaction accepted whole, no waits
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "pfc_params.svh"
`default_nettype none
module pfc_master
	import pfc_pkg::*;
#(
	parameter logic [7:0] REQ_QUEUE_CAPACITY = 8'h08,
	parameter int unsigned LEN_W              = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	input  wire logic             req_issue,
	output logic                  slot_avail,
	input  wire logic             lp_buf_full,
	input  wire logic             wr_buf_full,
	input  wire logic             rd_hold,
	input  wire logic             wr_data_ready,
	input  wire logic [LEN_W-1:0] xfer_len,
	input  wire logic             gnt_n,
	input  wire logic [2:0]       grant_status_code,
	input  wire logic             trdy_n,
	output logic                  irdy_n_out,
	output logic                  irdy_oe_n,
	output logic                  read_buffer_full_n,
	output logic                  write_buffer_full_n,
	output logic                  data_move
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	pfc_state_t    state_q, state_d;
	pfc_count_t    depth_q, limit, cnt_q, cnt_d;
	logic          frbf_q;
	logic [4:0]    pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
	logic          gnt_prev_q, gnt_f, gnt_edge, trdy_f;
	logic [2:0]    st_f;
	logic          start, is_read, is_write, wr_q, first_q;
	logic          move, blk_end, last, init_blk, issue, rel;

	function automatic logic code_is_read(input logic [2:0] c);
		return (c == `PFC_ST_LP_READ) || (c == `PFC_ST_HP_READ);
	endfunction

	function automatic logic code_is_write(input logic [2:0] c);
		return (c == `PFC_ST_LP_WRITE) || (c == `PFC_ST_HP_WRITE);
	endfunction

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			depth_q <= `PFC_DEPTH_RST;
			frbf_q  <= `PFC_FRBF_RST;
		end else if (reg_wr && reg_addr == `PFC_REG_CTRL) begin
			depth_q <= reg_wdata[`PFC_CTRL_DEPTH_MSB:`PFC_CTRL_DEPTH_LSB];
			frbf_q  <= reg_wdata[`PFC_CTRL_FRBF_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`PFC_REG_CTRL: begin
					reg_rdata <= {23'h000000, frbf_q, depth_q};
				end
				`PFC_REG_STATUS: begin
					reg_rdata <= {21'h000000, state_q == S_THROTTLE,
						state_q != S_IDLE, slot_avail, cnt_q};
				end
				`PFC_REG_CAP: begin
					reg_rdata <= {24'h000000, REQ_QUEUE_CAPACITY};
				end
				default: begin
					reg_rdata <= 32'h00000000;
				end
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// a bit changes only once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= `PFC_PINS_RST;
			pin_s2_q <= `PFC_PINS_RST;
			pin_s3_q <= `PFC_PINS_RST;
			pin_f_q  <= `PFC_PINS_RST;
		end else begin
			pin_s1_q <= {gnt_n, grant_status_code, trdy_n};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q  <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
		end
	end

	assign gnt_f  = !pin_f_q[4];
	assign st_f   = pin_f_q[3:1];
	assign trdy_f = !pin_f_q[0];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gnt_prev_q <= 1'b0;
		end else begin
			gnt_prev_q <= gnt_f;
		end
	end

	assign gnt_edge = gnt_f && !gnt_prev_q;
	assign is_read  = code_is_read(st_f);
	assign is_write = code_is_write(st_f);
	// high-priority returns start with no hold-off; rd_hold still throttles their later blocks
	assign start    = (state_q == S_IDLE) && gnt_edge && (is_read || is_write);

	// ----------------------------------------------------------------
	// request slot accounting
	// ----------------------------------------------------------------
	assign limit = (depth_q > REQ_QUEUE_CAPACITY) ? REQ_QUEUE_CAPACITY : depth_q;
	// one issue strobe is one slot, whatever the address width
	assign issue = req_issue && slot_avail;
	// a flush returns as a low-priority read, so it frees here too
	assign rel   = move && first_q && (cnt_q != 8'h00);

	always_comb begin
		cnt_d = cnt_q;
		unique case ({issue, rel})
			2'b10: cnt_d = cnt_q + 8'h01;
			2'b01: cnt_d = cnt_q - 8'h01;
			default: cnt_d = cnt_q;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q      <= 8'h00;
			slot_avail <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			slot_avail <= cnt_d < limit;
		end
	end

	// ----------------------------------------------------------------
	// buffer-full outputs
	// ----------------------------------------------------------------
	// only sampled by the arbiter before a grant; a granted return runs on
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			read_buffer_full_n  <= 1'b1;
			write_buffer_full_n <= 1'b1;
		end else begin
			read_buffer_full_n  <= !(lp_buf_full || frbf_q);
			write_buffer_full_n <= !wr_buf_full;
		end
	end

	// ----------------------------------------------------------------
	// data transfer sequencing
	// ----------------------------------------------------------------
	// target cannot stall an initial write block, so trdy is ignored there
	assign move = (state_q == S_XFER) && (trdy_f || (wr_q && init_blk));

	pfc_blk_cnt #(
		.BLK_CLKS (`PFC_BLOCK_CLKS),
		.LW       (LEN_W)
	) u_blk (
		.sys_clk     (sys_clk),
		.rst_b       (rst_b),
		.load        (start),
		.len         (xfer_len),
		.move        (move),
		.blk_end     (blk_end),
		.last        (last),
		.initial_blk (init_blk)
	);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (start && is_read) begin
					state_d = S_XFER;
				end else if (start) begin
					state_d = wr_data_ready ? S_XFER : S_WR_LEAD;
				end
			end
			S_WR_LEAD: begin
				state_d = S_XFER;
			end
			S_XFER: begin
				if (last) begin
					state_d = S_IDLE;
				end else if (blk_end && !wr_q && rd_hold) begin
					state_d = S_THROTTLE;
				end
			end
			S_THROTTLE: begin
				if (!rd_hold) begin
					state_d = S_XFER;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q    <= 1'b0;
			first_q <= 1'b0;
		end else if (start) begin
			wr_q    <= is_write;
			first_q <= 1'b1;
		end else if (move) begin
			first_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pin and user-side outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irdy_n_out <= 1'b1;
			irdy_oe_n  <= 1'b1;
			data_move  <= 1'b0;
		end else begin
			irdy_n_out <= state_d != S_XFER;
			irdy_oe_n  <= state_d == S_IDLE;
			data_move  <= move;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	a_cnt_within_limit: assert property (cnt_q <= limit || $past(limit) > limit)
		else $error("outstanding count above limit");

	a_cap_bound: assert property (cnt_q <= REQ_QUEUE_CAPACITY || $changed(depth_q))
		else $error("outstanding count above capacity");

	a_issue_counts: assert property (issue && !rel |=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("issue did not take a slot");

	a_release_frees: assert property (rel && !issue |=> cnt_q == $past(cnt_q) - 8'h01)
		else $error("data start did not free a slot");

	// a release in the same clock frees a slot at once
	a_full_blocks: assert property (cnt_q >= limit && !rel |=> !slot_avail)
		else $error("slot offered while full");

	a_both_same: assert property (issue && rel |=> $stable(cnt_q))
		else $error("count moved on issue plus release");

	a_wr_lead_once: assert property (state_q == S_WR_LEAD
		|=> state_q == S_XFER ##0 !irdy_n_out)
		else $error("write lead longer than one clock");

	a_wr_two_clk: assert property (start && is_write |-> ##[1:2] state_q == S_XFER)
		else $error("write data not presented within two clocks");

	a_rd_start: assert property (start && is_read |=> state_q == S_XFER && !irdy_n_out)
		else $error("read initial block stalled");

	a_throttle_edge: assert property (state_q == S_THROTTLE && $past(state_q) == S_XFER
		|-> $past(blk_end))
		else $error("throttle off a block boundary");

	a_wr_no_throttle: assert property (wr_q |-> state_q != S_THROTTLE)
		else $error("write block stalled");

	a_rbf_output: assert property (lp_buf_full |=> !read_buffer_full_n)
		else $error("read buffer full not signalled");

	a_hp_accept: assert property (gnt_edge && st_f == `PFC_ST_HP_READ && state_q == S_IDLE
		|=> state_q == S_XFER)
		else $error("high-priority return not accepted");

	// throttle keeps the bus driven, only irdy goes high
	a_throttle_irdy: assert property (state_q == S_THROTTLE |-> irdy_n_out && !irdy_oe_n)
		else $error("throttle without irdy high");

	a_wr_sub_go: assert property (wr_q && state_q == S_XFER && !init_blk |-> !irdy_n_out)
		else $error("subsequent write block stalled by master");

	a_short_block: assert property (blk_end && init_blk && last |=> state_q == S_IDLE)
		else $error("short transfer ran past its initial block");

	a_wr_start_drive: assert property (start && is_write |=> !irdy_oe_n)
		else $error("write grant not taken at once");

	c_throttle: cover property (state_q == S_XFER ##1 state_q == S_THROTTLE
		##[1:5] state_q == S_XFER);
	c_wr_lead: cover property (state_q == S_WR_LEAD);
	c_full: cover property (slot_avail ##1 !slot_avail ##[1:20] slot_avail);
	c_hp_read: cover property (start && st_f == `PFC_ST_HP_READ);
	c_wr_sub: cover property (wr_q && state_q == S_XFER && !init_blk);

endmodule
`default_nettype wire

// file: bench/pfc_core_model.sv
`default_nettype none
module pfc_core_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       go,
	input  wire logic [2:0] code,
	input  wire logic       slow,
	input  wire logic       read_buffer_full_n,
	input  wire logic       irdy_n_out,
	output logic            gnt_n,
	output logic      [2:0] grant_status_code,
	output logic            trdy_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// arbiter
	// ----------------------------------------------------------------
	logic       pend_q;
	logic [2:0] code_q;
	logic [2:0] hold_q;
	logic       dly_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
			code_q <= 3'h0;
			hold_q <= 3'h0;
		end else begin
			if (go) begin
				pend_q <= 1'b1;
				code_q <= code;
			end
			if (hold_q != 3'h0) begin
				hold_q <= hold_q - 3'h1;
			// full flag only gates the start of a low-priority return
			end else if (pend_q && (code_q != 3'h0 || read_buffer_full_n)) begin
				hold_q <= 3'h5;
				pend_q <= 1'b0;
			end
		end
	end

	assign gnt_n = (hold_q == 3'h0);
	// released status lines show the inverse, not a stale code
	assign grant_status_code = gnt_n ? ~code_q : code_q;

	// ----------------------------------------------------------------
	// target: slow mode delays readiness by one clock
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dly_q  <= 1'b0;
			trdy_n <= 1'b1;
		end else begin
			dly_q  <= !irdy_n_out;
			trdy_n <= !(!irdy_n_out && (!slow || dly_q));
		end
	end
endmodule
`default_nettype wire

// file: bench/pfc_master_tb_top.sv
`include "pfc_params.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module pfc_master_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        sys_clk = 1'b0, rst_b = 1'b0;
	logic [7:0]  reg_addr = 8'h00, xfer_len = 8'h01;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, req_issue = 1'b0, slot_avail;
	logic        lp_buf_full = 1'b0, wr_buf_full = 1'b0, rd_hold = 1'b0;
	logic        wr_data_ready = 1'b1, go = 1'b0, slow = 1'b0;
	logic [2:0]  code = 3'h0, grant_status_code;
	logic        gnt_n, trdy_n, irdy_n_out, irdy_oe_n, data_move;
	logic        read_buffer_full_n, write_buffer_full_n;
	logic [31:0] d;
	int          mismatches = 0, n_checks = 0, mv, gp;

	always #50 sys_clk = ~sys_clk;

	pfc_master u_pfc_master (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_issue(req_issue), .slot_avail(slot_avail), .lp_buf_full(lp_buf_full),
		.wr_buf_full(wr_buf_full), .rd_hold(rd_hold), .wr_data_ready(wr_data_ready),
		.xfer_len(xfer_len), .gnt_n(gnt_n), .grant_status_code(grant_status_code),
		.trdy_n(trdy_n), .irdy_n_out(irdy_n_out), .irdy_oe_n(irdy_oe_n),
		.read_buffer_full_n(read_buffer_full_n),
		.write_buffer_full_n(write_buffer_full_n), .data_move(data_move));

	pfc_core_model u_pfc_core_model (.sys_clk(sys_clk), .rst_b(rst_b), .go(go),
		.code(code), .slow(slow), .read_buffer_full_n(read_buffer_full_n),
		.irdy_n_out(irdy_n_out), .gnt_n(gnt_n), .grant_status_code(grant_status_code),
		.trdy_n(trdy_n));

	// ----------------------------------------------------------------
	// bus and link tasks
	// ----------------------------------------------------------------
	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// data stand through this cycle; take them at its closing edge
		@(posedge sys_clk);
		v = reg_rdata;
	endtask

	task automatic issue(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			req_issue <= 1'b1;
		end
		@(posedge sys_clk);
		req_issue <= 1'b0;
	endtask

	// counts data clocks and master wait states until the bus goes idle
	task automatic xfer(input logic [2:0] c, input logic [7:0] len, input bit start);
		int t;
		mv = 0;
		gp = 0;
		if (start) begin
			@(posedge sys_clk);
			code <= c;
			xfer_len <= len;
			go <= 1'b1;
			@(posedge sys_clk);
			go <= 1'b0;
		end
		for (t = 0; t < 40 && irdy_oe_n !== 1'b0; t++) @(posedge sys_clk);
		// a write lead cycle is already visible at the first driven edge
		if (irdy_oe_n === 1'b0 && irdy_n_out === 1'b1) gp++;
		t = 0;
		while (t < 100) begin
			@(posedge sys_clk);
			if (data_move === 1'b1) mv++;
			if (irdy_oe_n === 1'b0 && irdy_n_out === 1'b1) gp++;
			if (gp >= 3) rd_hold <= 1'b0;
			if (irdy_oe_n !== 1'b0 && t < 96) t = 96;
			t++;
		end
	endtask

	task automatic chk_count(input logic [7:0] e);
		reg_read(`PFC_REG_STATUS, d);
		`CHK("outstanding", e, d[7:0])
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		`CHK("slot_avail", 1'b0, slot_avail)
		`CHK("irdy_oe_n", 1'b1, irdy_oe_n)
		reg_read(`PFC_REG_CAP, d);
		`CHK("cap", 32'h8, d)
		reg_read(8'h0C, d);
		`CHK("unmapped", 32'h0, d)
		reg_write(`PFC_REG_CTRL, 32'h103);
		reg_read(`PFC_REG_CTRL, d);
		`CHK("ctrl", 32'h103, d)
		`CHK("rbf_forced", 1'b0, read_buffer_full_n)
		wr_buf_full <= 1'b1;
		reg_write(`PFC_REG_CTRL, 32'h3);
		`CHK("wbf", 1'b0, write_buffer_full_n)
		wr_buf_full <= 1'b0;
	endtask

	task automatic t_depth();
		issue(5);
		chk_count(8'h03);
		`CHK("slot_full", 1'b0, slot_avail)
		reg_write(`PFC_REG_CTRL, 32'h14);
		issue(8);
		chk_count(8'h08);
		`CHK("slot_cap", 1'b0, slot_avail)
		`CHK("stat_flags", 3'h0, d[10:8])
		`CHK("wbf_clear", 1'b1, write_buffer_full_n)
	endtask

	task automatic t_reads();
		rd_hold <= 1'b1;
		xfer(`PFC_ST_LP_READ, 8'h04, 1);
		`CHK("short_moves", 4, mv)
		`CHK("short_waits", 0, gp)
		chk_count(8'h07);
		`CHK("stat_avail", 3'h1, d[10:8])
		rd_hold <= 1'b1;
		xfer(`PFC_ST_LP_READ, 8'h06, 1);
		`CHK("long_moves", 6, mv)
		`CHK("long_waits", 1, int'(gp >= 3))
		lp_buf_full <= 1'b1;
		slow <= 1'b1;
		xfer(`PFC_ST_HP_READ, 8'h05, 1);
		`CHK("hp_moves", 5, mv)
		`CHK("hp_rbf", 1'b0, read_buffer_full_n)
		chk_count(8'h05);
	endtask

	task automatic t_lp_held();
		@(posedge sys_clk);
		code <= `PFC_ST_LP_READ;
		xfer_len <= 8'h02;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (30) @(posedge sys_clk);
		`CHK("held_off", 1'b1, irdy_oe_n)
		lp_buf_full <= 1'b0;
		xfer(`PFC_ST_LP_READ, 8'h02, 0);
		`CHK("held_moves", 2, mv)
		slow <= 1'b0;
	endtask

	task automatic t_writes();
		wr_data_ready <= 1'b0;
		rd_hold <= 1'b1;
		xfer(`PFC_ST_LP_WRITE, 8'h09, 1);
		`CHK("wr_moves", 9, mv)
		`CHK("wr_lead", 1, gp)
		wr_data_ready <= 1'b1;
		xfer(`PFC_ST_HP_WRITE, 8'h04, 1);
		`CHK("wr_nolead", 0, gp)
		chk_count(8'h02);
		rd_hold <= 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_depth();
		t_reads();
		t_lp_held();
		t_writes();
		conclude();
	end

	// whole run needs under 1000 clocks
	initial begin
		#2000000;
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
